/* core/dsec_ctrl.sv */
// debug state entry controller: entry causes, clock selection, core isolation
`include "dsec_params.svh"

// Functional notes
// [R1] normal operation runs core on memory clock, debug core clock held low
// [R2] debug core clock is derived from the test clock
// [R3] in debug, core runs on tap-gated debug clock, memory clock free runs
// [R4] the clock currently running the core is driven on selected clock output
// [R5] wait stretch is ignored while running from the debug core clock
// [R6] debug state halts and isolates the core, system keeps running
// [R7] debug entry on breakpoint, watchpoint or external debug request
// [R8] external logic drives break flag by rising edge after fetch data
// [R9] external logic marks load/store data with break flag, same timing
// [R10] debug acknowledge asserted once the core is in debug state
// [R11] breakpoint flagged at fetch, taken only when reaching execute
// [R12] breakpointed instruction never executes; state is that before it
// [R13] breakpoint in execute is taken whatever its condition result
// [R14] branch or pc write flush discards breakpoint flags, no entry
// [R15] exception flush cancels flags; refetch flags the instruction again
// [R16] watchpoint always taken, but only after current instruction ends
// [R17] watchpoint lets the instruction commit all state before entry
// [R18] watchpoint with pending exception enters in that exception's mode
// [R19] system drives debug feature enable high for full debug capability
// [R20] debug request synchronised, taken at instruction end or busy-wait
// [R21] in debug, memory cycles show internal, aborts and interrupts ignored
// [R22] switch to debug clock happens at next memory clock falling edge
// [R23] enable low forces break and request low, acknowledge low
// [R24] acknowledge drops after resync to memory clock on exit
module dsec_ctrl (
    input  wire logic                       clk_sys_i,
    input  wire logic                       srst_i,
    input  wire logic                       tck_i,
    input  wire logic                       tck_srst_i,
    input  wire logic                       tap_run_i,
    input  wire logic                       tap_restart_i,
    input  wire dsec_pkg::dsec_pipe_t       pipe_i,
    input  wire dsec_pkg::dsec_bus_t        core_bus_i,
    input  wire logic [`DSEC_MODE_W-1:0]    cur_mode_i,
    input  wire logic                       exc_pending_i,
    input  wire logic [`DSEC_MODE_W-1:0]    exc_mode_i,
    input  wire logic                       external_break_flag_i,
    input  wire logic                       debug_request_in_i,
    input  wire logic                       debug_feature_enable_i,
    input  wire logic                       wait_stretch_n_i,
    input  wire logic                       abort_i,
    input  wire logic                       irq_i,
    output logic                            debug_core_clock_o,
    output logic                            selected_clock_out_o,
    output logic                            debug_acknowledge_out_o,
    output dsec_pkg::dsec_bus_t             bus_o,
    output logic                            core_wait_n_o,
    output logic                            core_halt_o,
    output logic                            exec_suppress_o,
    output logic                            cp_abandon_o,
    output logic                            core_abort_o,
    output logic                            core_irq_o,
    output logic [`DSEC_CAUSE_W-1:0]        entry_cause_o,
    output logic [`DSEC_MODE_W-1:0]         entry_mode_o
);

    // edge of a toggle carried across a synchroniser
    function automatic logic tgl_edge(input logic a, input logic b);
        return a ^ b;
    endfunction

    //------------------------------------------------------------
    // test clock domain
    //------------------------------------------------------------
    logic dm_s1_q;
    logic dm_s2_q;
    logic debug_core_clock_q;
    logic rst_tgl_q;
    logic in_dbg_q;

    // debug level into test clock domain, two flops
    always_ff @(posedge tck_i) begin
        if (tck_srst_i) begin
            dm_s1_q <= `DSEC_BIT_RST;
            dm_s2_q <= `DSEC_BIT_RST;
        end else begin
            dm_s1_q <= in_dbg_q;
            dm_s2_q <= dm_s1_q;
        end
    end

    // debug core clock: toggles from tck only in debug with tap gating
    always_ff @(posedge tck_i) begin
        if (tck_srst_i) begin
            debug_core_clock_q <= `DSEC_BIT_RST;
        end else begin
            debug_core_clock_q <= dm_s2_q & tap_run_i & ~debug_core_clock_q;  // R1 R2 R3
        end
    end

    // restart event leaves the test domain as a toggle
    always_ff @(posedge tck_i) begin
        if (tck_srst_i) begin
            rst_tgl_q <= `DSEC_BIT_RST;
        end else if (tap_restart_i & dm_s2_q) begin
            rst_tgl_q <= ~rst_tgl_q;
        end
    end

    //------------------------------------------------------------
    // synchronisers into the memory clock domain
    //------------------------------------------------------------
    logic rq_s1_q, rq_s2_q;
    logic en_s1_q, en_s2_q;
    logic wt_s1_q, wt_s2_q;
    logic dk_s1_q, dk_s2_q;
    logic rs_s1_q, rs_s2_q, rs_s3_q;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rq_s1_q <= `DSEC_BIT_RST;
            rq_s2_q <= `DSEC_BIT_RST;
            en_s1_q <= `DSEC_BIT_RST;
            en_s2_q <= `DSEC_BIT_RST;
            wt_s1_q <= `DSEC_BIT_SET;
            wt_s2_q <= `DSEC_BIT_SET;
            dk_s1_q <= `DSEC_BIT_RST;
            dk_s2_q <= `DSEC_BIT_RST;
            rs_s1_q <= `DSEC_BIT_RST;
            rs_s2_q <= `DSEC_BIT_RST;
            rs_s3_q <= `DSEC_BIT_RST;
        end else begin
            rq_s1_q <= debug_request_in_i;  // R20
            rq_s2_q <= rq_s1_q;
            en_s1_q <= debug_feature_enable_i;
            en_s2_q <= en_s1_q;
            wt_s1_q <= wait_stretch_n_i;
            wt_s2_q <= wt_s1_q;
            dk_s1_q <= debug_core_clock_q;
            dk_s2_q <= dk_s1_q;
            rs_s1_q <= rst_tgl_q;
            rs_s2_q <= rs_s1_q;
            rs_s3_q <= rs_s2_q;
        end
    end

    //------------------------------------------------------------
    // breakpoint flags along the pipeline
    //------------------------------------------------------------
    dsec_pkg::dsec_state_t state_q, state_d;
    logic bp_dec_q, bp_dec_d;
    logic bp_exe_q, bp_exe_d;
    logic wp_pend_q, wp_pend_d;
    logic take_any;
    logic mem_tick_q;

    // gated requests toward the core
    wire brk_gated = external_break_flag_i & en_s2_q;  // R23 R8
    wire rq_gated  = rq_s2_q & en_s2_q;                // R23
    wire flush     = pipe_i.flush_branch | pipe_i.flush_exc;
    wire running   = (state_q == dsec_pkg::DSEC_RUN);
    wire fetch_brk = running & pipe_i.fetch_valid & ~pipe_i.data_access & brk_gated;

    // flag set at fetch, moved to execute, dropped by any flush
    assign bp_dec_d = flush ? `DSEC_BIT_RST                            // R14 R15
                    : fetch_brk ? `DSEC_BIT_SET                        // R11 R15
                    : pipe_i.advance ? `DSEC_BIT_RST : bp_dec_q;
    assign bp_exe_d = (flush | take_any) ? `DSEC_BIT_RST               // R14
                    : pipe_i.advance ? bp_dec_q : bp_exe_q;            // R11

    // watchpoint survives flushes and waits for instruction end
    wire wp_hit   = running & pipe_i.data_access & brk_gated;           // R9
    wire take_bp  = running & bp_exe_q;                                 // R11 R13
    wire take_wp  = running & ~bp_exe_q & (wp_pend_q | wp_hit) & pipe_i.instr_end;  // R16 R17
    wire take_rq  = running & ~bp_exe_q & ~take_wp & rq_gated
                  & (pipe_i.instr_end | pipe_i.busy_wait);              // R20
    assign take_any = take_bp | take_wp | take_rq;                      // R7

    assign wp_pend_d = take_wp ? `DSEC_BIT_RST
                     : (wp_hit | wp_pend_q) & en_s2_q;                  // R16

    // exception mode wins when a watchpoint meets a pending exception
    wire [`DSEC_MODE_W-1:0] wp_mode = exc_pending_i ? exc_mode_i : cur_mode_i;  // R18

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            bp_dec_q  <= `DSEC_BIT_RST;
            bp_exe_q  <= `DSEC_BIT_RST;
            wp_pend_q <= `DSEC_BIT_RST;
        end else begin
            bp_dec_q  <= bp_dec_d;
            bp_exe_q  <= bp_exe_d;
            wp_pend_q <= wp_pend_d;
        end
    end

    //------------------------------------------------------------
    // state machine and memory clock image
    //------------------------------------------------------------
    wire restart = tgl_edge(rs_s2_q, rs_s3_q);
    wire mem_fall = mem_tick_q;  // high phase now, falling edge next

    always_comb begin
        state_d = state_q;
        case (state_q)
            dsec_pkg::DSEC_RUN: begin
                if (take_any) begin
                    state_d = dsec_pkg::DSEC_SWITCH;
                end
            end
            dsec_pkg::DSEC_SWITCH: begin
                if (mem_fall) begin
                    state_d = dsec_pkg::DSEC_DEBUG;  // R22
                end
            end
            dsec_pkg::DSEC_DEBUG: begin
                if (restart) begin
                    state_d = dsec_pkg::DSEC_RESYNC;
                end
            end
            dsec_pkg::DSEC_RESYNC: begin
                if (mem_fall) begin
                    state_d = dsec_pkg::DSEC_RUN;  // R24
                end
            end
            default: begin
                state_d = dsec_pkg::DSEC_RUN;
            end
        endcase
    end

    wire in_dbg_d = (state_d == dsec_pkg::DSEC_DEBUG);
    wire halted_d = (state_d != dsec_pkg::DSEC_RUN);

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_q    <= dsec_pkg::DSEC_RUN;
            in_dbg_q   <= `DSEC_BIT_RST;
            mem_tick_q <= `DSEC_BIT_RST;
        end else begin
            state_q    <= state_d;
            in_dbg_q   <= in_dbg_d;
            mem_tick_q <= ~mem_tick_q;
        end
    end

    //------------------------------------------------------------
    // registered outputs
    //------------------------------------------------------------
    logic sel_clk_q, ack_q, halt_q, supp_q, cpab_q, abort_q, irq_q, wait_n_q;
    logic [`DSEC_CAUSE_W-1:0] cause_q;
    logic [`DSEC_MODE_W-1:0]  mode_q;
    dsec_pkg::dsec_bus_t      bus_q;

    wire [`DSEC_CAUSE_W-1:0] cause_d = take_bp ? `DSEC_CAUSE_BRK
                                     : take_wp ? `DSEC_CAUSE_WATCH : `DSEC_CAUSE_REQ;
    wire sel_clk_d = in_dbg_d ? dk_s2_q : ~mem_tick_q;  // R4 R3

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            sel_clk_q <= `DSEC_BIT_RST;
            ack_q     <= `DSEC_BIT_RST;
            halt_q    <= `DSEC_BIT_RST;
            supp_q    <= `DSEC_BIT_RST;
            cpab_q    <= `DSEC_BIT_RST;
            abort_q   <= `DSEC_BIT_RST;
            irq_q     <= `DSEC_BIT_RST;
            wait_n_q  <= `DSEC_BIT_SET;
            cause_q   <= `DSEC_CAUSE_NONE;
            mode_q    <= `DSEC_MODE_RST;
            bus_q     <= {`DSEC_MREQ_IDLE, `DSEC_SEQ_IDLE};
        end else begin
            sel_clk_q <= sel_clk_d;                                    // R4
            ack_q     <= halted_d & (state_d != dsec_pkg::DSEC_SWITCH) & en_s2_q;  // R10 R23 R24
            halt_q    <= halted_d | take_any;                          // R6 R12
            supp_q    <= bp_exe_d | take_bp;                           // R12 R13
            cpab_q    <= take_rq & pipe_i.busy_wait & ~pipe_i.instr_end;  // R20
            abort_q   <= abort_i & ~halted_d;                          // R21
            irq_q     <= irq_i & ~halted_d;                            // R21
            wait_n_q  <= in_dbg_d | wt_s2_q;                           // R5
            bus_q.memory_request_n <= halted_d ? `DSEC_MREQ_IDLE : core_bus_i.memory_request_n;  // R21
            bus_q.burst_cycle_flag <= halted_d ? `DSEC_SEQ_IDLE : core_bus_i.burst_cycle_flag;   // R21
            if (take_any) begin
                cause_q <= cause_d;
                mode_q  <= take_wp ? wp_mode : cur_mode_i;             // R18
            end
        end
    end

    assign debug_core_clock_o      = debug_core_clock_q;
    assign selected_clock_out_o    = sel_clk_q;
    assign debug_acknowledge_out_o = ack_q;
    assign bus_o                   = bus_q;
    assign core_wait_n_o           = wait_n_q;
    assign core_halt_o             = halt_q;
    assign exec_suppress_o         = supp_q;
    assign cp_abandon_o            = cpab_q;
    assign core_abort_o            = abort_q;
    assign core_irq_o              = irq_q;
    assign entry_cause_o           = cause_q;
    assign entry_mode_o            = mode_q;

    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    a_debug_core_clock_low_normal: assert property (@(posedge tck_i) disable iff (tck_srst_i)
        !dm_s2_q |=> !debug_core_clock_q) else $error("debug clock not low outside debug"); // R1
    a_debug_core_clock_from_tck: assert property (@(posedge tck_i) disable iff (tck_srst_i)
        dm_s2_q && tap_run_i && !debug_core_clock_q |=> debug_core_clock_q) else $error("debug clock did not pulse"); // R2 R3
    a_sel_clk_follow: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        in_dbg_q && $past(in_dbg_q) |-> sel_clk_q == $past(dk_s2_q)) else $error("selected clock wrong"); // R4
    a_wait_ignored: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        in_dbg_q |-> core_wait_n_o) else $error("wait stretch reached core in debug"); // R5
    a_bus_internal: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        state_q != dsec_pkg::DSEC_RUN |-> bus_q.memory_request_n && !bus_q.burst_cycle_flag && !irq_q)
        else $error("core not isolated in debug"); // R6 R21
    a_flush_cancel: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        flush |=> !bp_dec_q && !bp_exe_q) else $error("flush kept a break flag"); // R14 R15
    a_watch_waits: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        running && wp_pend_q && !pipe_i.instr_end && !bp_exe_q && !rq_gated
        |=> state_q == dsec_pkg::DSEC_RUN) else $error("watchpoint taken mid instruction"); // R16
    a_switch_fall: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        state_q == dsec_pkg::DSEC_SWITCH |-> ##[0:1] in_dbg_d ##1 ack_q || !en_s2_q)
        else $error("clock switch missed the falling edge"); // R22 R10
    a_ack_enable: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        !en_s2_q |=> !ack_q) else $error("acknowledge high while disabled"); // R23
    a_bp_execute: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        running && bp_exe_q |=> supp_q && state_q == dsec_pkg::DSEC_SWITCH)
        else $error("breakpoint in execute not taken"); // R11 R12 R13

    // exit, abandon, pass-through, watchpoint mode and refetch checks
    a_ack_with_halt: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R10 R24
        ack_q |-> halt_q)
        else $error("acknowledge high while core runs");
    a_pass_running: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R21
        running && !$past(srst_i) |-> abort_q == $past(abort_i) && irq_q == $past(irq_i))
        else $error("abort or interrupt blocked while running");
    a_bus_pass_run: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R6
        running && !$past(srst_i) |-> bus_q == $past(core_bus_i))
        else $error("cycle indicators not passed through");
    a_abandon_req: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R20
        cpab_q |-> halt_q && cause_q == `DSEC_CAUSE_REQ)
        else $error("abandon without request entry");
    a_wp_exc_mode: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R18
        take_wp && exc_pending_i |=> mode_q == $past(exc_mode_i))
        else $error("watchpoint entry mode wrong");
    a_refetch_flag: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R11 R15
        fetch_brk && !flush |=> bp_dec_q)
        else $error("flagged fetch not marked");

endmodule // dsec_ctrl

/* core/dsec_params.svh */
// constants for the debug state entry controller
`ifndef DSEC_PARAMS_SVH
`define DSEC_PARAMS_SVH

`define DSEC_MODE_W      5
`define DSEC_MODE_RST    5'h00
`define DSEC_CAUSE_W     2
`define DSEC_CAUSE_NONE  2'h0
`define DSEC_CAUSE_BRK   2'h1
`define DSEC_CAUSE_WATCH 2'h2
`define DSEC_CAUSE_REQ   2'h3
`define DSEC_BIT_RST     1'h0
`define DSEC_BIT_SET     1'h1
`define DSEC_MREQ_IDLE   1'h1
`define DSEC_SEQ_IDLE    1'h0

`endif

/* core/dsec_pkg.sv */
// types shared by the debug state entry controller
package dsec_pkg;

    // controller states
    typedef enum logic [2:0] {
        DSEC_RUN,
        DSEC_SWITCH,
        DSEC_DEBUG,
        DSEC_RESYNC
    } dsec_state_t;

    // pipeline events reported by the core, memory clock domain
    typedef struct packed {
        logic fetch_valid;   // instruction enters the pipeline
        logic advance;       // pipeline moves one stage
        logic flush_branch;  // branch or pc write flushes
        logic flush_exc;     // exception flushes
        logic instr_end;     // current instruction completes
        logic busy_wait;     // coprocessor access busy-waiting
        logic data_access;   // load or store data transfer
    } dsec_pipe_t;

    // memory cycle indicators
    typedef struct packed {
        logic memory_request_n;
        logic burst_cycle_flag;
    } dsec_bus_t;

endpackage : dsec_pkg

/* tb/dsec_far_model.sv */
// far side model: external break tagging logic and serial test port debugger
module dsec_far_model (
    input  wire logic clk_sys_i,
    input  wire logic arm_i,
    input  wire logic fetch_i,
    input  wire logic data_i,
    input  wire logic session_i,
    input  wire logic run_i,
    input  wire logic restart_req_i,
    output logic      external_break_flag_o,
    output logic      tck_o,
    output logic      tap_run_o,
    output logic      tap_restart_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic rs_q = 1'b0;

    // tag the transfer seen at the falling edge, valid by the next rising edge
    initial external_break_flag_o = 1'b0;
    always @(negedge clk_sys_i) external_break_flag_o <= arm_i & (fetch_i | data_i);

    // test clock runs only while the debugger holds a session, else stands low
    initial begin
        tck_o = 1'b0;
        #3.7;
        forever begin
            #16;
            tck_o <= session_i ? ~tck_o : 1'b0;
        end
    end

    // tap controls change just after the test clock rising edge
    initial tap_run_o = 1'b0;
    initial tap_restart_o = 1'b0;
    always @(posedge tck_o) begin
        tap_run_o     <= #1 run_i;
        tap_restart_o <= #1 restart_req_i & ~rs_q;
        rs_q          <= restart_req_i;
    end
endmodule // dsec_far_model

/* tb/testbench.sv */
// self-checking bench for the debug state entry controller
`include "dsec_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [1:0] kind;
        logic       exc;
        logic       busy;
        logic [1:0] cause;
        logic [4:0] mode;
        logic       chkm;
    } dsec_row_t;

    logic clk_sys_i = 1'b0, srst_i = 1'b1, tck_srst_i = 1'b1, tck_i, tap_run_i, tap_restart_i;
    logic exc_pending_i = 1'b0, external_break_flag_i, debug_request_in_i = 1'b0;
    logic debug_feature_enable_i = 1'b1, wait_stretch_n_i = 1'b1;
    logic arm = 1'b0, session = 1'b1, run = 1'b0, restart_req = 1'b0, sup_seen, ab_seen;
    dsec_pkg::dsec_pipe_t pipe_i = '0;
    dsec_pkg::dsec_bus_t  core_bus_i = 2'h1;
    dsec_pkg::dsec_bus_t  bus_o;
    logic debug_core_clock_o, selected_clock_out_o, debug_acknowledge_out_o, core_wait_n_o;
    logic core_halt_o, exec_suppress_o, cp_abandon_o, core_abort_o, core_irq_o;
    logic [`DSEC_CAUSE_W-1:0] entry_cause_o;
    logic [`DSEC_MODE_W-1:0]  entry_mode_o;
    int n_mismatch = 0, num_checks = 0, d, s;
    dsec_row_t rows [5] = '{
        '{2'h0, 1'b0, 1'b0, `DSEC_CAUSE_BRK, 5'h10, 1'b0},
        '{2'h1, 1'b0, 1'b0, `DSEC_CAUSE_WATCH, 5'h10, 1'b1},
        '{2'h1, 1'b1, 1'b0, `DSEC_CAUSE_WATCH, 5'h12, 1'b1},
        '{2'h2, 1'b0, 1'b0, `DSEC_CAUSE_REQ, 5'h10, 1'b0},
        '{2'h2, 1'b0, 1'b1, `DSEC_CAUSE_REQ, 5'h10, 1'b0}};

    dsec_ctrl dut (.clk_sys_i, .srst_i, .tck_i, .tck_srst_i, .tap_run_i, .tap_restart_i, .pipe_i,
        .core_bus_i, .cur_mode_i(5'h10), .exc_pending_i, .exc_mode_i(5'h12), .external_break_flag_i,
        .debug_request_in_i, .debug_feature_enable_i, .wait_stretch_n_i, .abort_i(1'b1), .irq_i(1'b1),
        .debug_core_clock_o, .selected_clock_out_o, .debug_acknowledge_out_o, .bus_o, .core_wait_n_o,
        .core_halt_o, .exec_suppress_o, .cp_abandon_o, .core_abort_o, .core_irq_o, .entry_cause_o,
        .entry_mode_o);

    dsec_far_model far (.clk_sys_i, .arm_i(arm), .fetch_i(pipe_i.fetch_valid), .data_i(pipe_i.data_access),
        .session_i(session), .run_i(run), .restart_req_i(restart_req),
        .external_break_flag_o(external_break_flag_i), .tck_o(tck_i), .tap_run_o(tap_run_i),
        .tap_restart_o(tap_restart_i));

    // memory clock
    always #5 clk_sys_i = ~clk_sys_i;

    // catch one-cycle pulses where they are settled
    always @(negedge clk_sys_i) begin
        sup_seen |= exec_suppress_o;
        ab_seen  |= cp_abandon_o;
    end

    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return core_halt_o;
            1: return debug_acknowledge_out_o;
            2: return !debug_acknowledge_out_o;
            default: return !core_halt_o;
        endcase
    endfunction

    task wait_for(input int w);
        int i;
        for (i = 0; i < 40 && pick(w) !== 1'b1; i++) step(1);
        if (i == 40) begin
            n_mismatch++;
            $display("unexpected at %0t: wait %h got %h expected %h", $time, w, 1'h0, 1'h1);
            finish_test();
        end
    endtask

    task count_hi;
        d = 0;
        s = 0;
        repeat (20) begin
            d += debug_core_clock_o;
            s += selected_clock_out_o;
            step(1);
        end
    endtask

    // flagged fetch, optionally flushed as it moves to execute
    task tag_fetch(input logic br, input logic ex);
        arm = 1'b1; pipe_i.fetch_valid = 1'b1; step(1);
        arm = 1'b0; pipe_i.fetch_valid = 1'b0; pipe_i.advance = 1'b1;
        pipe_i.flush_branch = br; pipe_i.flush_exc = ex; step(1);
        pipe_i = '0;
    endtask

    task enter(input dsec_row_t r);
        sup_seen = 1'b0; ab_seen = 1'b0; exc_pending_i = r.exc;
        if (r.kind == 2'h0) tag_fetch(1'b0, 1'b0);
        else if (r.kind == 2'h1) begin
            arm = 1'b1; pipe_i.data_access = 1'b1; step(1);
            arm = 1'b0; pipe_i.data_access = 1'b0; step(3);
            chk(core_halt_o, 0);
            pipe_i.instr_end = 1'b1; step(1); pipe_i.instr_end = 1'b0;
        end else begin
            debug_request_in_i = 1'b1; step(4);
            chk(core_halt_o, 0);
            pipe_i.busy_wait = r.busy; pipe_i.instr_end = !r.busy; step(1);
            pipe_i = '0;
        end
        wait_for(0);
        wait_for(1);
        debug_request_in_i = 1'b0; exc_pending_i = 1'b0;
        chk(entry_cause_o, r.cause);
        if (r.chkm) chk(entry_mode_o, r.mode);
        chk(sup_seen, r.kind == 2'h0);
        chk(ab_seen, r.busy);
        chk(bus_o, 2'h2);
        chk({core_abort_o, core_irq_o}, 0);
        wait_stretch_n_i = 1'b0; step(4);
        chk(core_wait_n_o, 1);
        wait_stretch_n_i = 1'b1; session = 1'b1; run = 1'b1; step(12);
        count_hi();
        chk(d > 0 && d < 20 && s > 0 && s < 20, 1);
        run = 1'b0; step(10);
        count_hi();
        chk(d == 0 && (s == 0 || s == 20), 1);
        restart_req = 1'b1; wait_for(2);
        chk(core_halt_o, 0);
        wait_for(3);
        restart_req = 1'b0; step(8);
        session = 1'b0;
        chk(bus_o, 2'h1);
    endtask

    // main sequence
    initial begin
        step(10);
        chk({bus_o, core_wait_n_o, debug_acknowledge_out_o, entry_cause_o, debug_core_clock_o}, 8'h50);
        srst_i = 1'b0; tck_srst_i = 1'b0; session = 1'b0; step(4);
        count_hi();
        chk(d == 0 && s == 10, 1);
        wait_stretch_n_i = 1'b0; step(4);
        chk(core_wait_n_o, 0);
        chk({core_abort_o, core_irq_o}, 8'h03);
        wait_stretch_n_i = 1'b1;
        for (int i = 0; i < 5; i++) enter(rows[i]);
        tag_fetch(1'b1, 1'b0); step(10);
        chk(core_halt_o, 0);
        tag_fetch(1'b0, 1'b1); step(10);
        chk(core_halt_o, 0);
        enter(rows[0]);
        debug_feature_enable_i = 1'b0; step(4);
        debug_request_in_i = 1'b1; tag_fetch(1'b0, 1'b0);
        pipe_i.instr_end = 1'b1; step(1); pipe_i.instr_end = 1'b0; step(8);
        chk({core_halt_o, debug_acknowledge_out_o}, 0);
        debug_request_in_i = 1'b0; debug_feature_enable_i = 1'b1; step(4);
        finish_test();
    end
endmodule // testbench
